// ===== common/psr_consts.svh
// Register offsets, codes and reset values of the port status bank.
`ifndef PSR_CONSTS_SVH
`define PSR_CONSTS_SVH
`define PSR_OFS_STARTUP_EVT 8'h08
`define PSR_OFS_STARTUP_COR 8'h09
`define PSR_OFS_SUPPLY_EVT 8'h0a
`define PSR_OFS_SUPPLY_COR 8'h0b
`define PSR_OFS_PORT1 8'h0c
`define PSR_OFS_PORT2 8'h0d
`define PSR_OFS_PORT3 8'h0e
`define PSR_OFS_PORT4 8'h0f
`define PSR_OFS_POWER 8'h10
`define PSR_OFS_STRAP 8'h11
`define PSR_OFS_POWER_EVT 8'h02
`define PSR_OFS_POWER_COR 8'h03
`define PSR_ZERO8 8'h00
`define PSR_ZERO4 4'h0
`define PSR_ZERO3 3'h0
`define PSR_ZERO2 2'h0
`define PSR_ZERO1 1'h0
`define PSR_PORTS 4
`define PSR_PORT_IDX_W 2
`define PSR_PINS 5
`define PSR_SETTLE_STEP 2'h1
`define PSR_SETTLE_LAST 2'h3
`define PSR_SLAVE_RST 7'h2f
`define PSR_SLAVE_FIXED 3'h2
`define PSR_SUPPLY_RST 4'h0
`define PSR_DET_UNKNOWN 3'h0
`define PSR_DET_POS_SUPPLY 3'h1
`define PSR_DET_LARGE_CAP 3'h2
`define PSR_DET_LOW_RES 3'h3
`define PSR_DET_VALID 3'h4
`define PSR_DET_HIGH_RES 3'h5
`define PSR_DET_OPEN 3'h6
`define PSR_DET_NEG_SHORT 3'h7
`define PSR_CLS_UNKNOWN 3'h0
`define PSR_CLS_FOUR 3'h4
`define PSR_CLS_FIVE 3'h5
`define PSR_CLS_ZERO 3'h6
`define PSR_CLS_LIMIT 3'h7
`endif

// ===== common/psr_pkg.sv
// Types shared by the port status bank.
package psr_pkg;
	typedef logic [2:0] psr_code_t;
	typedef enum logic {
		PSR_STRAP_WAIT,
		PSR_STRAP_HELD
	} psr_strap_state_t;
endpackage

// ===== logic/psr_pin_sync.sv
// Three-flop synchroniser with agreement filter for a pin input.
`include "psr_consts.svh"
module psr_pin_sync
	import psr_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_pin,
	output logic o_level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge i_mclk) begin
		s1_q <= i_pin;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	// A change counts only once the second and third stages agree.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_level <= `PSR_ZERO1;
		end else if (s2_q == s3_q) begin
			o_level <= s3_q;
		end
	end
endmodule

// ===== logic/psr_port_result.sv
// One port's detection and classification result field.
`include "psr_consts.svh"
module psr_port_result
	import psr_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_det_done,
	input wire psr_code_t i_det_code,
	input wire logic i_legacy_cap_accept,
	input wire logic i_cls_done,
	input wire psr_code_t i_cls_code,
	input wire logic i_cls_above_four,
	input wire logic i_class_five_accept,
	output psr_code_t o_detect_result_code,
	output psr_code_t o_class_result_code,
	output logic o_block_power
);
	psr_code_t det_d;
	psr_code_t cls_d;

	always_comb begin
		det_d = i_det_code;
		// Large capacitance is only reported as a result when legacy loads are accepted.
		if (i_det_code == `PSR_DET_LARGE_CAP && !i_legacy_cap_accept) begin
			det_d = `PSR_DET_UNKNOWN;
		end
		cls_d = i_cls_code;
		if (i_cls_above_four) begin
			cls_d = i_class_five_accept ? `PSR_CLS_FIVE : `PSR_CLS_LIMIT;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_detect_result_code <= `PSR_DET_UNKNOWN;
		end else if (i_det_done) begin
			o_detect_result_code <= det_d;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_class_result_code <= `PSR_CLS_UNKNOWN;
			o_block_power <= `PSR_ZERO1;
		end else if (i_cls_done) begin
			o_class_result_code <= cls_d;
			o_block_power <= (cls_d == `PSR_CLS_LIMIT);
		end
	end
endmodule

// ===== logic/psr_status_bank.sv
// Status and event register bank of a four-port power-sourcing controller.
`include "psr_consts.svh"
module psr_status_bank
	import psr_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	input wire logic [3:0] i_det_done,
	input wire logic [11:0] i_det_code,
	input wire logic [3:0] i_legacy_cap_accept,
	input wire logic [3:0] i_cls_done,
	input wire logic [11:0] i_cls_code,
	input wire logic [3:0] i_cls_above_four,
	input wire logic [3:0] i_class_five_accept,
	input wire logic [3:0] i_startup_end,
	input wire logic [3:0] i_vout_qualified,
	input wire logic [3:0] i_vout_low,
	input wire logic [3:0] i_port_fault,
	input wire logic [3:0] i_power_on,
	input wire logic [3:0] i_power_off,
	input wire logic [3:0] i_limit_timeout,
	input wire logic [3:0] i_startup_fail,
	input wire logic i_overtemp_recovered,
	input wire logic i_transistor_fault,
	input wire logic i_logic_supply_low,
	input wire logic i_main_supply_low,
	input wire logic i_strap_pin_3,
	input wire logic i_strap_pin_2,
	input wire logic i_strap_pin_1,
	input wire logic i_strap_pin_0,
	input wire logic i_auto_pin,
	output logic [3:0] o_power_good_bit,
	output logic [3:0] o_port_powered_bit,
	output logic [3:0] o_class_block,
	output logic [1:0] o_group_strap,
	output logic [1:0] o_identifier_strap,
	output logic o_auto_strap,
	output logic [6:0] o_slave_address,
	output logic [3:0] o_power_change_flag
);
	// ------------------------------------------------------------
	// Per-port result fields
	// ------------------------------------------------------------
	psr_code_t det_res [`PSR_PORTS];
	psr_code_t cls_res [`PSR_PORTS];
	logic [3:0] blk;
	genvar gp;
	generate
		for (gp = 0; gp < `PSR_PORTS; gp++) begin : g_port
			psr_port_result u_res (
				.i_mclk(i_mclk),
				.i_rst(i_rst),
				.i_det_done(i_det_done[gp]),
				.i_det_code(i_det_code[gp*3 +: 3]),
				.i_legacy_cap_accept(i_legacy_cap_accept[gp]),
				.i_cls_done(i_cls_done[gp]),
				.i_cls_code(i_cls_code[gp*3 +: 3]),
				.i_cls_above_four(i_cls_above_four[gp]),
				.i_class_five_accept(i_class_five_accept[gp]),
				.o_detect_result_code(det_res[gp]),
				.o_class_result_code(cls_res[gp]),
				.o_block_power(blk[gp])
			);
		end
	endgenerate

	// A second flop keeps every top-level output registered.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_class_block <= `PSR_ZERO4;
		end else begin
			o_class_block <= blk;
		end
	end

	// ------------------------------------------------------------
	// Power status and change tracking
	// ------------------------------------------------------------
	logic [3:0] pg_d;
	logic [3:0] pe_d;
	always_comb begin
		pg_d = o_power_good_bit;
		pe_d = o_port_powered_bit;
		for (int p = 0; p < `PSR_PORTS; p++) begin
			if (i_power_off[p]) begin
				pe_d[p] = `PSR_ZERO1;
			end else if (i_power_on[p]) begin
				pe_d[p] = 1'b1;
			end
			// Clearing causes win so that a fault never leaves a stale good state.
			if (i_vout_low[p] || i_port_fault[p] || !pe_d[p]) begin
				pg_d[p] = `PSR_ZERO1;
			end else if (i_startup_end[p] && i_vout_qualified[p]) begin
				pg_d[p] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_power_good_bit <= `PSR_ZERO4;
			o_port_powered_bit <= `PSR_ZERO4;
		end else begin
			o_power_good_bit <= pg_d;
			o_port_powered_bit <= pe_d;
		end
	end

	// ------------------------------------------------------------
	// Event registers
	// ------------------------------------------------------------
	logic rd_cor_power;
	logic rd_cor_startup;
	logic rd_cor_supply;
	logic [7:0] pwr_evt_q;
	logic [7:0] start_evt_q;
	logic [3:0] sup_evt_q;
	logic [7:0] pwr_set;
	logic [7:0] start_set;
	logic [3:0] sup_set;
	assign rd_cor_power = i_rd && (i_addr == `PSR_OFS_POWER_COR);
	assign rd_cor_startup = i_rd && (i_addr == `PSR_OFS_STARTUP_COR);
	assign rd_cor_supply = i_rd && (i_addr == `PSR_OFS_SUPPLY_COR);
	// Set terms come from the next power state so a change is caught in the cycle it happens.
	logic [3:0] pg_chg;
	logic [3:0] pe_chg;
	assign pg_chg = pg_d ^ o_power_good_bit;
	assign pe_chg = pe_d ^ o_port_powered_bit;
	assign pwr_set = {pg_chg, pe_chg};
	assign start_set = {i_limit_timeout, i_startup_fail};
	assign sup_set = {i_overtemp_recovered, i_transistor_fault,
		i_logic_supply_low, i_main_supply_low};

	// A clear-on-read keeps any event that lands in the same cycle.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			pwr_evt_q <= `PSR_ZERO8;
		end else begin
			pwr_evt_q <= (rd_cor_power ? `PSR_ZERO8 : pwr_evt_q) | pwr_set;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			start_evt_q <= `PSR_ZERO8;
		end else begin
			start_evt_q <= (rd_cor_startup ? `PSR_ZERO8 : start_evt_q) | start_set;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sup_evt_q <= `PSR_SUPPLY_RST;
		end else begin
			sup_evt_q <= (rd_cor_supply ? `PSR_ZERO4 : sup_evt_q) | sup_set;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_power_change_flag <= `PSR_ZERO4;
		end else begin
			o_power_change_flag <= pwr_evt_q[7:4] | pwr_evt_q[3:0];
		end
	end

	// ------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------
	logic [4:0] pin_raw;
	logic [4:0] pin_lvl;
	psr_strap_state_t strap_q;
	assign pin_raw = {i_strap_pin_3, i_strap_pin_2, i_strap_pin_1, i_strap_pin_0, i_auto_pin};
	generate
		for (gp = 0; gp < `PSR_PINS; gp++) begin : g_pin
			psr_pin_sync u_sync (
				.i_mclk(i_mclk),
				.i_rst(i_rst),
				.i_pin(pin_raw[gp]),
				.o_level(pin_lvl[gp])
			);
		end
	endgenerate

	// Capture waits a few cycles after release so the synchronisers hold real levels.
	logic [1:0] settle_q;
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			strap_q <= PSR_STRAP_WAIT;
			settle_q <= `PSR_ZERO2;
			o_group_strap <= `PSR_ZERO2;
			o_identifier_strap <= `PSR_ZERO2;
			o_auto_strap <= `PSR_ZERO1;
		end else begin
			unique case (strap_q)
				PSR_STRAP_WAIT: begin
					settle_q <= settle_q + `PSR_SETTLE_STEP;
					if (settle_q == `PSR_SETTLE_LAST) begin
						o_group_strap <= pin_lvl[4:3];
						o_identifier_strap <= pin_lvl[2:1];
						o_auto_strap <= pin_lvl[0];
						strap_q <= PSR_STRAP_HELD;
					end
				end
				PSR_STRAP_HELD: begin
					strap_q <= PSR_STRAP_HELD;
				end
			endcase
		end
	end

	// The upper address bits are fixed; all straps high gives 0101111.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_slave_address <= `PSR_SLAVE_RST;
		end else begin
			o_slave_address <= {`PSR_SLAVE_FIXED, o_group_strap, o_identifier_strap};
		end
	end

	// ------------------------------------------------------------
	// Read words
	// ------------------------------------------------------------
	// Reserved bits are tied low here so every register reads them as zero.
	logic [7:0] port_word [`PSR_PORTS];
	logic [7:0] power_word;
	logic [7:0] supply_word;
	logic [7:0] strap_word;
	generate
		for (gp = 0; gp < `PSR_PORTS; gp++) begin : g_word
			assign port_word[gp] = {`PSR_ZERO1, cls_res[gp], `PSR_ZERO1, det_res[gp]};
		end
	endgenerate
	assign power_word = {o_power_good_bit, o_port_powered_bit};
	assign supply_word = {sup_evt_q, `PSR_ZERO4};
	assign strap_word = {`PSR_ZERO2, o_group_strap, o_identifier_strap, `PSR_ZERO1,
		o_auto_strap};

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Unmapped offsets read as zero; there is no write path.
	logic [7:0] rd_d;
	always_comb begin
		rd_d = `PSR_ZERO8;
		unique case (i_addr)
			`PSR_OFS_POWER_EVT, `PSR_OFS_POWER_COR: rd_d = pwr_evt_q;
			`PSR_OFS_STARTUP_EVT, `PSR_OFS_STARTUP_COR: rd_d = start_evt_q;
			`PSR_OFS_SUPPLY_EVT, `PSR_OFS_SUPPLY_COR: rd_d = supply_word;
			`PSR_OFS_PORT1: rd_d = port_word[0];
			`PSR_OFS_PORT2: rd_d = port_word[1];
			`PSR_OFS_PORT3: rd_d = port_word[2];
			`PSR_OFS_PORT4: rd_d = port_word[3];
			`PSR_OFS_POWER: rd_d = power_word;
			`PSR_OFS_STRAP: rd_d = strap_word;
			default: rd_d = `PSR_ZERO8;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_rdata <= `PSR_ZERO8;
		end else if (i_rd) begin
			o_rdata <= rd_d;
		end
	end

	// The answer strobe follows every taken read by exactly one cycle.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_rvalid <= `PSR_ZERO1;
		end else begin
			o_rvalid <= i_rd;
		end
	end
endmodule

// ===== testbench/psr_status_bank_monitor.sv
// Concurrent checks on the ports of the port status bank.
module psr_status_bank_monitor
	import psr_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_rd,
	input wire logic o_rvalid,
	input wire logic [3:0] i_power_on,
	input wire logic [3:0] i_power_off,
	input wire logic [3:0] i_vout_low,
	input wire logic [3:0] i_port_fault,
	input wire logic [3:0] i_startup_end,
	input wire logic [3:0] i_vout_qualified,
	input wire logic [3:0] o_power_good_bit,
	input wire logic [3:0] o_port_powered_bit,
	input wire logic [3:0] o_power_change_flag,
	input wire logic [1:0] o_group_strap,
	input wire logic [1:0] o_identifier_strap,
	input wire logic [6:0] o_slave_address
);
	// ----------------------------------------
	// Settle counter
	// ----------------------------------------
	// Straps need several cycles after reset to pass the synchroniser.
	logic [3:0] up_q;
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			up_q <= 4'h0;
		end else if (up_q != 4'hf) begin
			up_q <= up_q + 4'h1;
		end
	end
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	read_answer_a: assert property (i_rd |=> o_rvalid)
		else $error("read not answered");
	no_spurious_a: assert property (!i_rd |=> !o_rvalid)
		else $error("stray read answer");
	power_on_a: assert property (i_power_on[1] && !i_power_off[1] |=> o_port_powered_bit[1])
		else $error("powered bit not set");
	power_off_a: assert property (i_power_off[1] && !i_power_on[1] |=> !o_port_powered_bit[1])
		else $error("powered bit not cleared");
	good_drop_a: assert property (i_vout_low[1] || i_port_fault[1] |=> !o_power_good_bit[1])
		else $error("power good kept");
	good_rise_a: assert property ($rose(o_power_good_bit[1])
		|-> $past(i_startup_end[1]) && $past(i_vout_qualified[1])) else $error("power good early");
	change_flag_a: assert property ($changed(o_power_good_bit[1])
		|| $changed(o_port_powered_bit[1]) |=> o_power_change_flag[1])
		else $error("change not flagged");
	strap_hold_a: assert property (up_q == 4'hf |=> $stable({o_group_strap, o_identifier_strap}))
		else $error("strap moved");
	slave_addr_a: assert property (up_q == 4'hf
		|-> o_slave_address == {3'h2, o_group_strap, o_identifier_strap})
		else $error("slave address wrong");
	cover property (i_rd ##1 o_rvalid);
	cover property ($rose(o_power_good_bit[1]));
	cover property ($fell(o_port_powered_bit[1]));
endmodule
bind psr_status_bank psr_status_bank_monitor i_mon (.*);

// ===== testbench/psr_host_model.sv
// Host model that reads the bank's registers over the read strobe.
module psr_host_model
	import psr_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rvalid,
	input wire logic [7:0] i_rdata,
	output logic o_rd,
	output logic [7:0] o_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_rd = 1'b0;
		o_addr = 8'hff;
	end
	// The address is inverted once released so a stale value never passes for a held one.
	task automatic read(input logic [7:0] a, output logic [7:0] v);
		@(negedge i_mclk);
		o_rd = 1'b1;
		o_addr = a;
		@(negedge i_mclk);
		o_rd = 1'b0;
		o_addr = ~a;
		v = i_rvalid ? i_rdata : 8'hxx;
	endtask
endmodule

// ===== testbench/psr_status_bank_bench.sv
// Self-checking bench for the port status bank.
module psr_status_bank_bench
	import psr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {int p; psr_code_t d; psr_code_t c; logic l; logic f; logic a; logic [7:0] e;} psr_row_t;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic i_rd;
	logic [7:0] i_addr, o_rdata, v;
	logic o_rvalid, o_auto_strap;
	logic [3:0] i_det_done = 4'h0, i_legacy_cap_accept = 4'h0, i_cls_done = 4'h0;
	logic [3:0] i_cls_above_four = 4'h0, i_class_five_accept = 4'h0, i_startup_end = 4'h0;
	logic [3:0] i_vout_qualified = 4'h0, i_vout_low = 4'h0, i_port_fault = 4'h0;
	logic [3:0] i_power_on = 4'h0, i_power_off = 4'h0, i_limit_timeout = 4'h0, i_startup_fail = 4'h0;
	logic [11:0] i_det_code = 12'h000, i_cls_code = 12'h000;
	logic i_overtemp_recovered = 1'b0, i_transistor_fault = 1'b0;
	logic i_logic_supply_low = 1'b0, i_main_supply_low = 1'b0;
	logic i_strap_pin_3 = 1'b1, i_strap_pin_2 = 1'b0, i_strap_pin_1 = 1'b1, i_strap_pin_0 = 1'b1;
	logic i_auto_pin = 1'b1;
	logic [3:0] o_power_good_bit, o_port_powered_bit, o_class_block, o_power_change_flag;
	logic [1:0] o_group_strap, o_identifier_strap;
	logic [6:0] o_slave_address;
	int errors = 0, num_checks = 0, cyc = 0;
	psr_row_t rows[4] = '{'{1, 3'h2, 3'h6, 1'b1, 1'b0, 1'b0, 8'h62},
		'{2, 3'h4, 3'h4, 1'b0, 1'b1, 1'b1, 8'h54}, '{3, 3'h4, 3'h4, 1'b0, 1'b0, 1'b1, 8'h74},
		'{0, 3'h2, 3'h3, 1'b0, 1'b0, 1'b0, 8'h30}};
	psr_status_bank i_dut (.*);
	psr_host_model i_host (.i_mclk, .i_rvalid(o_rvalid), .i_rdata(o_rdata), .o_rd(i_rd),
		.o_addr(i_addr));
	initial begin
		forever #10 i_mclk = ~i_mclk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		i_host.read(a, v);
		check(v, e);
	endtask
	task automatic tick;
		@(negedge i_mclk);
	endtask
	// Detection and class end together; the above-four level only qualifies the done pulse.
	task automatic phase(input psr_row_t r);
		tick;
		i_det_done[r.p] = 1'b1;
		i_cls_done[r.p] = 1'b1;
		i_det_code[3*r.p+:3] = r.d;
		i_cls_code[3*r.p+:3] = r.c;
		i_legacy_cap_accept[r.p] = r.l;
		i_class_five_accept[r.p] = r.f;
		i_cls_above_four[r.p] = r.a;
		tick;
		i_det_done = 4'h0;
		i_cls_done = 4'h0;
		i_cls_above_four = 4'h0;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			give_verdict;
		end
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (16) tick;
		i_rst = 1'b0;
		repeat (10) tick;
		for (int a = 12; a < 17; a++) rchk(8'(a), 8'h00);
		rchk(8'h11, 8'h2d);
		check({6'h0, o_group_strap}, 8'h02);
		check({3'h0, o_identifier_strap, 2'h0, o_auto_strap}, 8'h19);
		check({1'b0, o_slave_address}, 8'h2b);
		i_strap_pin_3 = 1'b0;
		i_strap_pin_1 = 1'b0;
		repeat (10) tick;
		rchk(8'h11, 8'h2d);
		rchk(8'h20, 8'h00);
		$display("test reset and straps done");
		for (int k = 0; k < 8; k++) begin
			phase('{0, 3'(k), 3'(k), 1'b1, 1'b1, 1'b0, 8'h00});
			rchk(8'h0c, {1'b0, 3'(k), 1'b0, 3'(k)});
		end
		foreach (rows[i]) begin
			phase(rows[i]);
			rchk(8'h0c + 8'(rows[i].p), rows[i].e);
			check({7'h0, o_class_block[rows[i].p]}, {7'h0, rows[i].e[6:4] == 3'h7});
		end
		rchk(8'h0d, 8'h62);
		$display("test result fields done");
		tick;
		i_limit_timeout = 4'h8;
		i_startup_fail = 4'h1;
		tick;
		i_limit_timeout = 4'h0;
		i_startup_fail = 4'h0;
		rchk(8'h08, 8'h81);
		rchk(8'h09, 8'h81);
		rchk(8'h08, 8'h00);
		{i_overtemp_recovered, i_transistor_fault, i_logic_supply_low, i_main_supply_low} = 4'hf;
		tick;
		{i_overtemp_recovered, i_transistor_fault, i_logic_supply_low, i_main_supply_low} = 4'h0;
		rchk(8'h0a, 8'hf0);
		rchk(8'h0b, 8'hf0);
		rchk(8'h0a, 8'h00);
		$display("test event registers done");
		i_vout_qualified[1] = 1'b1;
		i_power_on[1] = 1'b1;
		tick;
		i_power_on = 4'h0;
		rchk(8'h10, 8'h02);
		check({o_power_good_bit, o_port_powered_bit}, 8'h02);
		i_startup_end[1] = 1'b1;
		tick;
		i_startup_end = 4'h0;
		rchk(8'h10, 8'h22);
		rchk(8'h03, 8'h22);
		rchk(8'h02, 8'h00);
		i_vout_low[1] = 1'b1;
		i_vout_qualified[1] = 1'b0;
		tick;
		i_vout_low = 4'h0;
		rchk(8'h10, 8'h02);
		i_vout_qualified[1] = 1'b1;
		i_startup_end[1] = 1'b1;
		tick;
		i_startup_end = 4'h0;
		check({o_power_good_bit, o_port_powered_bit}, 8'h22);
		i_port_fault[1] = 1'b1;
		tick;
		i_port_fault = 4'h0;
		rchk(8'h10, 8'h02);
		i_power_off[1] = 1'b1;
		tick;
		i_power_off = 4'h0;
		rchk(8'h10, 8'h00);
		check({4'h0, o_power_change_flag}, 8'h02);
		rchk(8'h03, 8'h22);
		tick;
		check({4'h0, o_power_change_flag}, 8'h00);
		$display("test power status done");
		i_rst = 1'b1;
		repeat (2) tick;
		i_rst = 1'b0;
		rchk(8'h0d, 8'h00);
		repeat (8) tick;
		rchk(8'h11, 8'h05);
		check({1'b0, o_slave_address}, 8'h21);
		$display("test second reset done");
		give_verdict;
	end
endmodule
